// file: src/pcn_pkg.sv
// Package for the pin change notification block: map, fields, states and carriers
package pcn_pkg;
  localparam int PIN_NUM = 24;
  localparam int PIN_LO_NUM = 16;
  localparam int PIN_HI_NUM = 8;
  localparam int ADDR_W = 4;
  // Byte addresses, one aligned word per register
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_LO = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_HI = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PULLUP_LO = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_PULLUP_HI = 4'hC;
  localparam int IDX_CTRL = 4;
  localparam int IDX_PORT_LO = 5;
  localparam int IDX_PORT_HI = 6;
  localparam int IDX_STATUS = 7;
  localparam int IDX_STAT_CLR = 8;
  localparam int IDX_STAT_EN = 9;
  localparam int WORD_W = 32;
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [15:0] HI_MASK = 16'h00FF;
  // Control word fields
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_FLAG_BIT = 1;
  localparam int CTRL_PRIO_LSB = 4;
  localparam int CTRL_CPU_PRIO_LSB = 8;
  localparam int PRIO_W = 3;
  // Status / event bits
  localparam int EV_CHANGE_BIT = 0;
  localparam int EV_WAKE_BIT = 1;
  localparam int EV_W = 2;

  typedef enum logic [1:0] {
    PCN_RUN = 2'b00,
    PCN_SLEEP = 2'b01,
    PCN_IDLE = 2'b10
  } pcn_power_type;

  typedef struct packed {
    logic [15:0] irq_en_lo;
    logic [15:0] irq_en_hi;
    logic [15:0] pullup_lo;
    logic [15:0] pullup_hi;
    logic change_irq_flag;
    logic change_irq_enable;
    logic [PRIO_W-1:0] change_prio;
    logic [PRIO_W-1:0] cpu_prio;
    logic [PIN_NUM-1:0] sync1;
    logic [PIN_NUM-1:0] sync2;
    logic [PIN_NUM-1:0] last_read;
    pcn_power_type power;
    logic wake;
    logic wake_vector;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] status_en;
    logic irq;
    logic low_power;
    logic change_irq;
    logic [31:0] rdata;
    logic ack;
  } pcn_state_type;
endpackage

// file: src/pcn_top.sv
// Pin change notification block with wake logic and Avalon-MM register slave
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// - Change detection keeps running in sleep and idle states.
// - Any change on an enabled pin sets the shared change flag.
// - Flag set with change interrupt enabled wakes from sleep or idle.
// - Change priority not above CPU priority resumes after sleep instruction.
// - Change priority above CPU priority resumes at the change vector.
// - Low enable register holds read/write change enables for pins 0-15.
// - High enable register holds pins 16-23 enables; upper byte reads zero.
// - Low pull-up register holds read/write pull-up enables for pins 0-15.
// - High pull-up register holds pins 16-23 pull-ups; upper byte reads zero.
// - All enable and pull-up bits clear to zero at reset.
// - Reading the port clears the mismatch and re-arms detection.
module pcn_top #(
  parameter int PINS = pcn_pkg::PIN_NUM
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [pcn_pkg::ADDR_W+1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Pins and power management
  input wire logic [pcn_pkg::PIN_NUM-1:0] pin_in,
  input wire logic sleep_req_in,
  input wire logic idle_req_in,
  output logic [pcn_pkg::PIN_NUM-1:0] pin_pullup_enable_out,
  output logic low_power_out,
  output logic wake_out,
  output logic wake_vector_out,
  output logic change_irq_out,
  output logic irq_out
);
  if (PINS != pcn_pkg::PIN_NUM) begin : g_bad_pins
    $error("pcn_top supports only 24 pins");
  end

  // Word indices of the two enable and two pull-up registers, widened to the decode width
  localparam logic [3:0] W_EN_LO = {2'b00, pcn_pkg::OFS_IRQ_EN_LO[pcn_pkg::ADDR_W-1:2]};
  localparam logic [3:0] W_EN_HI = {2'b00, pcn_pkg::OFS_IRQ_EN_HI[pcn_pkg::ADDR_W-1:2]};
  localparam logic [3:0] W_PU_LO = {2'b00, pcn_pkg::OFS_PULLUP_LO[pcn_pkg::ADDR_W-1:2]};
  localparam logic [3:0] W_PU_HI = {2'b00, pcn_pkg::OFS_PULLUP_HI[pcn_pkg::ADDR_W-1:2]};
  localparam logic [3:0] W_CTRL = 4'(pcn_pkg::IDX_CTRL);
  localparam logic [3:0] W_PORT_LO = 4'(pcn_pkg::IDX_PORT_LO);
  localparam logic [3:0] W_PORT_HI = 4'(pcn_pkg::IDX_PORT_HI);
  localparam logic [3:0] W_STATUS = 4'(pcn_pkg::IDX_STATUS);
  localparam logic [3:0] W_STAT_CLR = 4'(pcn_pkg::IDX_STAT_CLR);
  localparam logic [3:0] W_STAT_EN = 4'(pcn_pkg::IDX_STAT_EN);

  pcn_pkg::pcn_state_type cur;
  pcn_pkg::pcn_state_type nxt;
  logic [pcn_pkg::PIN_NUM-1:0] pin_change_enable;
  logic mismatch;
  logic access;
  logic [3:0] word_idx;

  // Word index of a byte address; registers use only aligned words
  function automatic logic [3:0] word_of(input logic [pcn_pkg::ADDR_W+1:0] a);
    word_of = a[pcn_pkg::ADDR_W+1:2];
  endfunction

  function automatic logic [31:0] lo16(input logic [15:0] v);
    lo16 = {16'h0000, v};
  endfunction

  assign pin_change_enable = {cur.irq_en_hi[7:0], cur.irq_en_lo};
  assign mismatch = |((cur.sync2 ^ cur.last_read) & pin_change_enable);
  // One-wait access: waitrequest drops in the cycle after the request
  assign access = (avs_read_in | avs_write_in) & ~cur.ack;
  assign word_idx = word_of(avs_address_in);

  always_comb begin
    nxt = cur;
    nxt.ack = access;
    nxt.wake = 1'b0;
    nxt.wake_vector = 1'b0;
    nxt.sync1 = pin_in;
    nxt.sync2 = cur.sync1;
    // Write decode
    // Writes land at the edge where the master sees waitrequest low
    if (cur.ack && avs_write_in) begin
      if (word_idx == W_EN_LO) begin
        nxt.irq_en_lo = avs_writedata_in[15:0];
      end else if (word_idx == W_EN_HI) begin
        nxt.irq_en_hi = avs_writedata_in[15:0] & pcn_pkg::HI_MASK;
      end else if (word_idx == W_PU_LO) begin
        nxt.pullup_lo = avs_writedata_in[15:0];
      end else if (word_idx == W_PU_HI) begin
        nxt.pullup_hi = avs_writedata_in[15:0] & pcn_pkg::HI_MASK;
      end else if (word_idx == 4'(pcn_pkg::IDX_CTRL)) begin
        nxt.change_irq_enable = avs_writedata_in[pcn_pkg::CTRL_IRQ_EN_BIT];
        // Flag is write-zero-to-clear; software clears it before enabling
        if (!avs_writedata_in[pcn_pkg::CTRL_FLAG_BIT]) begin
          nxt.change_irq_flag = 1'b0;
        end
        nxt.change_prio = avs_writedata_in[pcn_pkg::CTRL_PRIO_LSB +: pcn_pkg::PRIO_W];
        nxt.cpu_prio = avs_writedata_in[pcn_pkg::CTRL_CPU_PRIO_LSB +: pcn_pkg::PRIO_W];
      end else if (word_idx == 4'(pcn_pkg::IDX_STAT_CLR)) begin
        nxt.status = cur.status & ~avs_writedata_in[pcn_pkg::EV_W-1:0];
      end else if (word_idx == 4'(pcn_pkg::IDX_STAT_EN)) begin
        nxt.status_en = avs_writedata_in[pcn_pkg::EV_W-1:0];
      end
    end
    // Read decode; port reads capture the snapshot
    nxt.rdata = 32'h0000_0000;
    if (access && avs_read_in) begin
      if (word_idx == W_EN_LO) begin
        nxt.rdata = lo16(cur.irq_en_lo);
      end else if (word_idx == W_EN_HI) begin
        nxt.rdata = lo16(cur.irq_en_hi & pcn_pkg::HI_MASK);
      end else if (word_idx == W_PU_LO) begin
        nxt.rdata = lo16(cur.pullup_lo);
      end else if (word_idx == W_PU_HI) begin
        nxt.rdata = lo16(cur.pullup_hi & pcn_pkg::HI_MASK);
      end else if (word_idx == 4'(pcn_pkg::IDX_CTRL)) begin
        nxt.rdata = {21'h000000, cur.cpu_prio, 1'b0, cur.change_prio,
                     2'h0, cur.change_irq_flag, cur.change_irq_enable};
      end else if (word_idx == 4'(pcn_pkg::IDX_PORT_LO)) begin
        nxt.rdata = lo16(cur.sync2[15:0]);
        nxt.last_read[15:0] = cur.sync2[15:0];
      end else if (word_idx == 4'(pcn_pkg::IDX_PORT_HI)) begin
        nxt.rdata = {24'h000000, cur.sync2[23:16]};
        nxt.last_read[23:16] = cur.sync2[23:16];
      end else if (word_idx == 4'(pcn_pkg::IDX_STATUS)) begin
        nxt.rdata = {30'h00000000, cur.status};
      end else if (word_idx == 4'(pcn_pkg::IDX_STAT_EN)) begin
        nxt.rdata = {30'h00000000, cur.status_en};
      end
    end
    // Detection runs in every power state; set wins over clear
    if (mismatch) begin
      nxt.change_irq_flag = 1'b1;
      nxt.status[pcn_pkg::EV_CHANGE_BIT] = 1'b1;
    end
    // Power state machine
    case (cur.power)
      pcn_pkg::PCN_RUN: begin
        if (sleep_req_in) begin
          nxt.power = pcn_pkg::PCN_SLEEP;
        end else if (idle_req_in) begin
          nxt.power = pcn_pkg::PCN_IDLE;
        end
      end
      pcn_pkg::PCN_SLEEP, pcn_pkg::PCN_IDLE: begin
        if (cur.change_irq_flag && cur.change_irq_enable) begin
          nxt.power = pcn_pkg::PCN_RUN;
          nxt.wake = 1'b1;
          nxt.wake_vector = cur.change_prio > cur.cpu_prio;
          nxt.status[pcn_pkg::EV_WAKE_BIT] = 1'b1;
        end
      end
      default: begin
        nxt.power = pcn_pkg::PCN_RUN;
      end
    endcase
    nxt.irq = |(nxt.status & nxt.status_en);
    // Registered copies so that every output leaves a flip-flop
    nxt.low_power = nxt.power != pcn_pkg::PCN_RUN;
    nxt.change_irq = nxt.change_irq_flag & nxt.change_irq_enable;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cur <= '0;
      cur.power <= pcn_pkg::PCN_RUN;
    end else begin
      cur <= nxt;
    end
  end

  assign avs_readdata_out = cur.rdata;
  assign avs_waitrequest_out = ~cur.ack;
  assign pin_pullup_enable_out = {cur.pullup_hi[7:0], cur.pullup_lo};
  assign low_power_out = cur.low_power;
  assign wake_out = cur.wake;
  assign wake_vector_out = cur.wake_vector;
  assign change_irq_out = cur.change_irq;
  assign irq_out = cur.irq;

  a_flag_on_change: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mismatch |=> cur.change_irq_flag) else $error("change flag not set");
  a_wake_exit: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cur.power != pcn_pkg::PCN_RUN && cur.change_irq_flag && cur.change_irq_enable)
    |=> wake_out && !low_power_out) else $error("no wake");
  a_wake_resume: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wake_out && $past(cur.change_prio) <= $past(cur.cpu_prio)) |-> !wake_vector_out)
    else $error("vectored at low priority");
  a_wake_vector: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wake_out && $past(cur.change_prio) > $past(cur.cpu_prio)) |-> wake_vector_out)
    else $error("no vector at high priority");
  a_hi_upper_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cur.irq_en_hi[15:8] == 8'h00 && cur.pullup_hi[15:8] == 8'h00)
    else $error("upper byte set");
  a_reset_clear: assert property (@(posedge clk_in)
    !rstn_in |=> pin_pullup_enable_out == 24'h000000 && !change_irq_out)
    else $error("reset not clear");
  a_read_rearm: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == 4'(pcn_pkg::IDX_PORT_LO))
    |=> cur.last_read[15:0] == $past(cur.sync2[15:0])) else $error("no rearm");
  a_sleep_detect: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (low_power_out && mismatch) |=> cur.change_irq_flag)
    else $error("lost change in low power");
  a_ack_one: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (avs_read_in || avs_write_in) |-> ##[0:1] !avs_waitrequest_out)
    else $error("bus slow");

  // Register file: writes, reads and unimplemented bits
  a_en_lo_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cur.ack && avs_write_in && word_idx == W_EN_LO)
    |=> cur.irq_en_lo == $past(avs_writedata_in[15:0])) else $error("enable lo write");
  a_en_hi_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cur.ack && avs_write_in && word_idx == W_EN_HI)
    |=> cur.irq_en_hi == ($past(avs_writedata_in[15:0]) & pcn_pkg::HI_MASK))
    else $error("enable hi write");
  a_pu_lo_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cur.ack && avs_write_in && word_idx == W_PU_LO)
    |=> cur.pullup_lo == $past(avs_writedata_in[15:0])) else $error("pull-up lo write");
  a_pu_hi_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cur.ack && avs_write_in && word_idx == W_PU_HI)
    |=> cur.pullup_hi == ($past(avs_writedata_in[15:0]) & pcn_pkg::HI_MASK))
    else $error("pull-up hi write");
  a_en_lo_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == W_EN_LO)
    |=> avs_readdata_out == {16'h0000, $past(cur.irq_en_lo)}) else $error("enable lo read");
  a_en_hi_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == W_EN_HI)
    |=> avs_readdata_out[31:8] == 24'h000000) else $error("enable hi upper bits");
  a_pu_lo_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == W_PU_LO)
    |=> avs_readdata_out == {16'h0000, $past(cur.pullup_lo)}) else $error("pull-up lo read");
  a_pu_hi_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == W_PU_HI)
    |=> avs_readdata_out[31:8] == 24'h000000) else $error("pull-up hi upper bits");
  a_pullup_drive: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pin_pullup_enable_out == {cur.pullup_hi[7:0], cur.pullup_lo})
    else $error("pull-up pins differ");

  // Reset leaves every enable, pull-up and power output clear
  a_reset_enables: assert property (@(posedge clk_in)
    !rstn_in |=> cur.irq_en_lo == 16'h0000 && cur.irq_en_hi == 16'h0000)
    else $error("enables not cleared");
  a_reset_pullups: assert property (@(posedge clk_in)
    !rstn_in |=> cur.pullup_lo == 16'h0000 && cur.pullup_hi == 16'h0000)
    else $error("pull-ups not cleared");
  a_reset_power: assert property (@(posedge clk_in)
    !rstn_in |=> !low_power_out && !wake_out && !wake_vector_out && !irq_out)
    else $error("power outputs not cleared");
  a_reset_flag: assert property (@(posedge clk_in)
    !rstn_in |=> !cur.change_irq_flag && !cur.change_irq_enable)
    else $error("flag not cleared");

  // Bus handshake: one wait cycle, then a single ready cycle
  a_wait_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !avs_waitrequest_out |=> avs_waitrequest_out) else $error("ready held");
  a_idle_bus: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(avs_read_in || avs_write_in) |=> avs_waitrequest_out) else $error("ready unasked");

  // Sampling chain and port snapshot
  a_sync_first: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $past(rstn_in) |-> cur.sync1 == $past(pin_in)) else $error("first stage");
  a_sync_second: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $past(rstn_in) |-> cur.sync2 == $past(cur.sync1)) else $error("second stage");
  a_rearm_hi: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == W_PORT_HI)
    |=> cur.last_read[23:16] == $past(cur.sync2[23:16])) else $error("no rearm hi");
  a_port_lo_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == W_PORT_LO)
    |=> avs_readdata_out == {16'h0000, $past(cur.sync2[15:0])}) else $error("port lo data");
  a_port_hi_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (access && avs_read_in && word_idx == W_PORT_HI)
    |=> avs_readdata_out == {24'h000000, $past(cur.sync2[23:16])})
    else $error("port hi data");

  // Flag and status behaviour
  a_flag_cause: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!cur.change_irq_flag && !mismatch) |=> !cur.change_irq_flag)
    else $error("flag without change");
  a_idle_detect: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cur.power == pcn_pkg::PCN_IDLE && mismatch) |=> cur.change_irq_flag)
    else $error("lost change in idle");
  a_status_sticky: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cur.status[pcn_pkg::EV_CHANGE_BIT] && !(cur.ack && avs_write_in && word_idx == W_STAT_CLR))
    |=> cur.status[pcn_pkg::EV_CHANGE_BIT]) else $error("status lost");
  a_irq_level: assert property (@(posedge clk_in) disable iff (!rstn_in)
    irq_out == |(cur.status & cur.status_en)) else $error("irq level");
  a_change_irq: assert property (@(posedge clk_in) disable iff (!rstn_in)
    change_irq_out == (cur.change_irq_flag && cur.change_irq_enable))
    else $error("change irq level");

  // Power states and wake pulses
  a_low_power_lvl: assert property (@(posedge clk_in) disable iff (!rstn_in)
    low_power_out == (cur.power != pcn_pkg::PCN_RUN)) else $error("low power level");
  a_wake_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wake_out |=> !wake_out) else $error("wake held");
  a_wake_origin: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wake_out |-> $past(low_power_out)) else $error("wake from run");
  a_no_wake_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (low_power_out && !cur.change_irq_enable) |=> !wake_out && low_power_out)
    else $error("wake while disabled");
  a_vector_pair: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wake_vector_out |-> wake_out) else $error("vector without wake");
  a_wake_status: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wake_out |-> cur.status[pcn_pkg::EV_WAKE_BIT]) else $error("wake not logged");

  c_wake_idle: cover property (@(posedge clk_in) disable iff (!rstn_in)
    cur.power == pcn_pkg::PCN_IDLE ##1 wake_out);
  c_wake_resume: cover property (@(posedge clk_in) disable iff (!rstn_in)
    wake_out && !wake_vector_out);
  c_wake_sleep: cover property (@(posedge clk_in) disable iff (!rstn_in)
    cur.power == pcn_pkg::PCN_SLEEP ##1 wake_out);
  c_wake_vec: cover property (@(posedge clk_in) disable iff (!rstn_in) wake_vector_out);
  c_port_read: cover property (@(posedge clk_in) disable iff (!rstn_in)
    cur.change_irq_flag ##1 (access && word_idx == 4'(pcn_pkg::IDX_PORT_LO)));
endmodule // pcn_top

// file: tb/pcn_power_model.sv
// Power manager model: requests sleep or idle and records each wake
`timescale 1ns/1ns
module pcn_power_model (
  // Clock, reset and bench command
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [1:0] cmd_in,
  // Block side
  input wire logic low_power_in,
  input wire logic wake_in,
  input wire logic wake_vector_in,
  output logic sleep_req_out,
  output logic idle_req_out,
  output logic woke_out,
  output logic vector_out
);
  logic entered;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      {sleep_req_out, idle_req_out, woke_out, vector_out, entered} <= 5'h00;
    end else begin
      // Drop the request once asleep, or a wake would put it straight back
      if (low_power_in) begin
        {sleep_req_out, idle_req_out, entered} <= 3'h1;
      end else if (!entered && cmd_in != 2'h0) begin
        sleep_req_out <= cmd_in == 2'h1;
        idle_req_out <= cmd_in == 2'h2;
      end
      if (cmd_in == 2'h0) begin
        {entered, woke_out} <= 2'h0;
      end
      if (wake_in) begin
        woke_out <= 1'b1;
        vector_out <= wake_vector_in;
      end
    end
  end
endmodule // pcn_power_model

// file: tb/pcn_top_tb_top.sv
// Register, change detection, wake and interrupt tests for the block
`timescale 1ns/1ns
module pcn_top_tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [23:0] pin = 24'h000000;
  logic [1:0] cmd = 2'h0;
  logic [31:0] rdat, q, cw;
  logic [23:0] pu;
  logic wreq, slp, idl, lp, wk, wv, cirq, irq, woke, vec;
  int n_fail = 0;
  int checked = 0;
  initial forever #4 clk_in = ~clk_in;
  pcn_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .pin_in(pin), .sleep_req_in(slp), .idle_req_in(idl),
    .pin_pullup_enable_out(pu), .low_power_out(lp), .wake_out(wk), .wake_vector_out(wv),
    .change_irq_out(cirq), .irq_out(irq));
  pcn_power_model pm (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(cmd), .low_power_in(lp),
    .wake_in(wk), .wake_vector_in(wv), .sleep_req_out(slp), .idle_req_out(idl),
    .woke_out(woke), .vector_out(vec));
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) n_fail++;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(ref logic s);
    for (int n = 0; n < 30 && s !== 1'b1; n++) @(posedge clk_in);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 6'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    chk(pu, 24'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 6'(i * 4), 32'hFFFFFFFF);
      bus(1'b0, 6'(i * 4), 32'h0);
      chk(q, i[0] ? 32'h000000FF : 32'h0000FFFF);
    end
    chk(pu, 24'hFFFFFF);
    bus(1'b0, 6'h3C, 32'h0);
    chk(q, 32'h0);
    // Only pin 0 and pin 23 may raise the flag from here on
    bus(1'b1, 6'h00, 32'h00000001);
    bus(1'b1, 6'h04, 32'h00000080);
    bus(1'b0, 6'h14, 32'h0);
    bus(1'b0, 6'h18, 32'h0);
    bus(1'b1, 6'h10, 32'h0);
    pin <= 24'h000002;
    repeat (6) @(posedge clk_in);
    bus(1'b0, 6'h10, 32'h0);
    chk(q[1], 1'b0);
    pin <= 24'h800002;
    repeat (6) @(posedge clk_in);
    bus(1'b0, 6'h10, 32'h0);
    chk(q[1], 1'b1);
    bus(1'b0, 6'h18, 32'h0);
    bus(1'b1, 6'h10, 32'h0);
    repeat (6) @(posedge clk_in);
    bus(1'b0, 6'h10, 32'h0);
    chk(q[1], 1'b0);
    for (int k = 0; k < 2; k++) begin
      cw = {21'h0, 3'h3, 1'b0, k[0] ? 3'h4 : 3'h2, 4'h0};
      bus(1'b1, 6'h10, cw);
      cmd <= k[0] ? 2'h2 : 2'h1;
      wt(lp);
      chk(lp, 1'b1);
      bus(1'b1, 6'h10, cw | 32'h1);
      pin <= pin ^ 24'h000001;
      wt(woke);
      chk(woke, 1'b1);
      chk(vec, k[0]);
      chk(lp, 1'b0);
      chk(cirq, 1'b1);
      cmd <= 2'h0;
      bus(1'b0, 6'h14, 32'h0);
    end
    bus(1'b0, 6'h1C, 32'h0);
    chk(q, 32'h3);
    chk(irq, 1'b0);
    bus(1'b1, 6'h24, 32'h1);
    repeat (2) @(posedge clk_in);
    chk(irq, 1'b1);
    bus(1'b1, 6'h20, 32'h3);
    repeat (2) @(posedge clk_in);
    chk(irq, 1'b0);
    bus(1'b0, 6'h1C, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule // pcn_top_tb_top
